// *** logic/lcf_cell.sv ***
// function stage, output inversion, edge flag and register slave of one logic cell
`timescale 1ns/1ps
`include "lcf_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - modes 000 and-or, 001 or-xor, 010 four-input and of gates
// - modes 011 to 111 give latch, flip-flop and j-k storage functions
// - each function takes the four gate outputs and makes one output
// - function result passes inversion, then drives pin, peripherals, feedback
// - output invert bit set inverts function result, clear passes it
// - toggling output invert is an output change and may set the flag
// - rise and fall detectors on final output set flag when enabled
// - control bit 4 enables rising edges to set the flag
// - control bit 3 enables falling edges to set the flag
// - software clears flag; an edge in the clear cycle keeps it set
// - mirror register shows all cell outputs sampled in one instant
// - reset clears control register; polarity settings are kept
// - cell keeps working while the processor sleeps
// - fast oscillator kept running while enabled cell selects it
// - control bit 7 enables the cell; clear forces output to zero
// - control bit 5 reads the final output, writes ignored
// - control bit 6 reads zero and ignores writes
// - polarity bits 3..0 invert each gate output before the function
// - each gate is an and of its enabled true or negated inputs
module lcf_cell
   import lcf_pkg::*;
#(
   parameter int NUM_CELLS = 4,
   parameter int CELL_INDEX = 0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] gate_raw_i,
   input wire logic fosc_selected_i,
   input wire logic [NUM_CELLS-1:0] other_out_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic cell_output_signal_o,
   output logic cell_irq_flag_o,
   output logic fosc_keep_o
);

   initial begin
      if (NUM_CELLS < 1 || NUM_CELLS > 8 || CELL_INDEX >= NUM_CELLS) begin
         $error("lcf_cell: cell count or index out of range");
      end
   end

   lcf_state_t s_r;
   lcf_state_t s_nxt;
   lcf_wb_req_t req;
   logic [3:0] g;
   logic cell_en;
   logic [2:0] mode;
   logic func_out;
   logic final_out;
   logic rise;
   logic fall;
   logic set_flag;
   logic wr;
   logic rd;
   logic [NUM_CELLS-1:0] mirror;

   assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i, sel: sel_i, dat: dat_i};
   assign wr = req.cyc && req.stb && req.we && !s_r.ack;
   assign rd = req.cyc && req.stb && !req.we && !s_r.ack;
   assign cell_en = s_r.ctrl[`LCF_EN_BIT];
   assign mode = s_r.ctrl[`LCF_MODE_LSB +: 3];

   ////////////////////////////////////////////////////////////////////////////
   // gate inputs come from another domain, so two flops first; gate logic is upstream
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pol
         assign g[gi] = s_r.gate_s2[gi] ^ s_r.pol[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // function stage; storage modes are modelled synchronously on clk_i
   logic store_nxt;
   always_comb begin
      func_out = 1'b0;
      store_nxt = s_r.store;
      case (lcf_mode_t'(mode))
         LCF_AND_OR: func_out = (g[0] & g[1]) | (g[2] & g[3]);
         LCF_OR_XOR: func_out = (g[0] | g[1]) ^ (g[2] | g[3]);
         LCF_AND4: func_out = &g;
         LCF_SR_LATCH: begin
            if (g[2] | g[3]) begin
               store_nxt = 1'b0;
            end else if (g[0] | g[1]) begin
               store_nxt = 1'b1;
            end
            func_out = s_r.store;
         end
         LCF_DFF_SR: begin
            if (g[2]) begin
               store_nxt = 1'b0;
            end else if (g[3]) begin
               store_nxt = 1'b1;
            end else if (g[0] && !s_r.ck_prev) begin
               store_nxt = g[1];
            end
            func_out = s_r.store;
         end
         LCF_DFF2_R: begin
            if (g[2]) begin
               store_nxt = 1'b0;
            end else if (g[0] && !s_r.ck_prev) begin
               store_nxt = g[1] & g[3];
            end
            func_out = s_r.store;
         end
         LCF_JK_R: begin
            if (g[2]) begin
               store_nxt = 1'b0;
            end else if (g[0] && !s_r.ck_prev) begin
               case ({g[1], g[3]})
                  2'b10: store_nxt = 1'b1;
                  2'b01: store_nxt = 1'b0;
                  2'b11: store_nxt = !s_r.store;
                  default: store_nxt = s_r.store;
               endcase
            end
            func_out = s_r.store;
         end
         LCF_DLATCH_SR: begin
            if (g[2]) begin
               store_nxt = 1'b0;
            end else if (g[3]) begin
               store_nxt = 1'b1;
            end else if (!g[0]) begin
               store_nxt = g[1];
            end
            func_out = store_nxt;
         end
         default: func_out = 1'b0;
      endcase
   end

   // disabled cell outputs zero after the inversion stage
   assign final_out = cell_en & (func_out ^ s_r.pol[`LCF_OINV_BIT]);
   assign rise = final_out && !s_r.out_prev;
   assign fall = !final_out && s_r.out_prev;
   assign set_flag = (rise && s_r.ctrl[`LCF_RISE_BIT]) || (fall && s_r.ctrl[`LCF_FALL_BIT]);

   always_comb begin
      mirror = other_out_i;
      mirror[CELL_INDEX] = final_out;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state and register slave
   always_comb begin
      s_nxt = s_r;
      s_nxt.gate_s1 = gate_raw_i;
      s_nxt.gate_s2 = s_r.gate_s1;
      s_nxt.store = cell_en ? store_nxt : 1'b0;
      s_nxt.ck_prev = g[0];
      s_nxt.out_prev = final_out;
      s_nxt.ack = req.cyc && req.stb && !s_r.ack;
      if (wr && req.sel[0]) begin
         case (req.adr)
            `LCF_CTRL_OFF: s_nxt.ctrl = req.dat[7:0] & `LCF_CTRL_WMASK;
            `LCF_POL_OFF: s_nxt.pol = req.dat[7:0] & `LCF_POL_WMASK;
            `LCF_FLAG_OFF: if (req.dat[0]) s_nxt.flag = 1'b0;
            default: s_nxt.ctrl = s_r.ctrl;
         endcase
      end
      if (set_flag) begin
         s_nxt.flag = 1'b1;
      end
      if (rd) begin
         case (req.adr)
            `LCF_CTRL_OFF: s_nxt.rdata = {24'h000000, s_r.ctrl[7:6],
                                          final_out, s_r.ctrl[4:0]};
            `LCF_POL_OFF: s_nxt.rdata = {24'h000000, s_r.pol};
            `LCF_MIRROR_OFF: s_nxt.rdata = 32'(mirror);
            `LCF_FLAG_OFF: s_nxt.rdata = {31'h00000000, s_r.flag};
            default: s_nxt.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r.ctrl <= `LCF_CTRL_RST;
         s_r.store <= 1'b0;
         s_r.out_prev <= 1'b0;
         s_r.ck_prev <= 1'b0;
         s_r.flag <= 1'b0;
         s_r.rdata <= 32'h00000000;
         s_r.ack <= 1'b0;
         s_r.gate_s1 <= 4'h0;
         s_r.gate_s2 <= 4'h0;
         s_r.pol <= s_nxt.pol;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dat_o = s_r.rdata;
   assign ack_o = s_r.ack;
   assign cell_output_signal_o = final_out;
   assign cell_irq_flag_o = s_r.flag;
   assign fosc_keep_o = cell_en && fosc_selected_i;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence edge_enabled_s;
      set_flag;
   endsequence

   flag_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
      edge_enabled_s |=> s_r.flag)
      else $error("enabled edge did not set flag");
   disabled_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cell_en |-> !cell_output_signal_o)
      else $error("disabled cell output not zero");
   rise_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ($rose(cell_output_signal_o) && s_r.ctrl[4]) |=> cell_irq_flag_o)
      else $error("rising edge lost");
   fall_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ($fell(cell_output_signal_o) && s_r.ctrl[3]) |=> cell_irq_flag_o)
      else $error("falling edge lost");
   no_spurious_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!s_r.flag && !set_flag) |=> !s_r.flag)
      else $error("flag set without enabled edge");
   and4_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && mode == 3'h2 && !s_r.pol[7]) |-> (final_out == &g))
      else $error("and mode wrong");
   ctrl_bit6_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !s_r.ctrl[6])
      else $error("bit 6 set");
   invert_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cell_en |-> (final_out == (func_out ^ s_r.pol[7])))
      else $error("output inversion wrong");
   ctrl_reset_a: assert property (@(posedge clk_i)
      rst_i |=> (s_r.ctrl == 8'h00))
      else $error("control not cleared by reset");

   // storage checks read the decoded mode so each names the function it guards
   lcf_mode_t fmode;
   assign fmode = lcf_mode_t'(mode);

   sequence clk_rise_s;
      g[0] && !s_r.ck_prev;
   endsequence

   sequence clear_req_s;
      wr && req.sel[0] && (req.adr == `LCF_FLAG_OFF) && req.dat[0];
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   // register slave: one-cycle answer, lane select and read-only fields
   ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("request not answered in one cycle");
   ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("acknowledge held too long");
   lane_refused_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && !req.sel[0]) |=> (s_r.ctrl == $past(s_r.ctrl)))
      else $error("write without lane changed control");
   read_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd |=> (dat_o[31:8] == 24'h000000))
      else $error("upper read bits not zero");
   out_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && (req.adr == `LCF_CTRL_OFF)) |=> (dat_o[`LCF_OUT_BIT] == $past(final_out)))
      else $error("output bit does not show final output");
   bit6_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && (req.adr == `LCF_CTRL_OFF)) |=> !dat_o[6])
      else $error("bit 6 read as one");
   mirror_own_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd && (req.adr == `LCF_MIRROR_OFF)) |=> (dat_o[CELL_INDEX] == $past(final_out)))
      else $error("mirror slot does not show own output");

   ////////////////////////////////////////////////////////////////////////////
   // flag: a set in the clear cycle must survive, disabled edges never set it
   flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (clear_req_s ##0 !set_flag) |=> !s_r.flag)
      else $error("flag not cleared");
   clear_collide_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (clear_req_s ##0 edge_enabled_s) |=> s_r.flag)
      else $error("edge lost during clear");
   rise_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!s_r.flag && rise && !s_r.ctrl[`LCF_RISE_BIT]) |=> !s_r.flag)
      else $error("disabled rising edge set flag");
   fall_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!s_r.flag && fall && !s_r.ctrl[`LCF_FALL_BIT]) |=> !s_r.flag)
      else $error("disabled falling edge set flag");

   ////////////////////////////////////////////////////////////////////////////
   // combinational functions with the output not inverted
   andor_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && (fmode == LCF_AND_OR) && !s_r.pol[`LCF_OINV_BIT])
      |-> (final_out == ((g[0] & g[1]) | (g[2] & g[3]))))
      else $error("and-or mode wrong");
   orxor_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && (fmode == LCF_OR_XOR) && !s_r.pol[`LCF_OINV_BIT])
      |-> (final_out == ((g[0] | g[1]) ^ (g[2] | g[3]))))
      else $error("or-xor mode wrong");

   // storage functions: reset first, then set, then capture on a gate 0 rise (transparent latch: while gate 0 is low)
   sr_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && (fmode == LCF_SR_LATCH) && (g[2] | g[3])) |=> !s_r.store)
      else $error("s-r latch not reset");
   sr_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && (fmode == LCF_SR_LATCH) && !(g[2] | g[3]) && (g[0] | g[1]))
      |=> s_r.store)
      else $error("s-r latch not set");
   dff_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && (fmode == LCF_DFF_SR) && !g[2] && g[3]) |=> s_r.store)
      else $error("flip-flop not set");
   dff_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && (fmode == LCF_DFF_SR) && !g[2] && !g[3]) ##0 clk_rise_s
      |=> (s_r.store == $past(g[1])))
      else $error("flip-flop did not capture");
   dff2_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && (fmode == LCF_DFF2_R) && !g[2]) ##0 clk_rise_s
      |=> (s_r.store == $past(g[1] & g[3])))
      else $error("two-input flip-flop did not capture");
   jk_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && (fmode == LCF_JK_R) && g[2]) |=> !s_r.store)
      else $error("j-k not reset");
   jk_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && (fmode == LCF_JK_R) && !g[2] && g[1] && g[3]) ##0 clk_rise_s
      |=> (s_r.store != $past(s_r.store)))
      else $error("j-k did not toggle");
   latch_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && (fmode == LCF_DLATCH_SR) && g[2]) |=> !s_r.store)
      else $error("transparent latch not reset");
   latch_open_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && (fmode == LCF_DLATCH_SR) && !g[2] && !g[3] && !g[0])
      |-> (func_out == g[1]))
      else $error("open latch not transparent");
   disabled_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cell_en |=> !s_r.store)
      else $error("disabled cell kept stored state");
   fosc_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cell_en && fosc_selected_i) |-> fosc_keep_o)
      else $error("oscillator keep request missing");
endmodule // lcf_cell

// *** include/lcf_map.svh ***
// register offsets, field positions and reset values of the logic cell output stage
`ifndef LCF_MAP_SVH
`define LCF_MAP_SVH
`define LCF_CTRL_OFF 4'h0
`define LCF_POL_OFF 4'h4
`define LCF_MIRROR_OFF 4'h8
`define LCF_FLAG_OFF 4'hc
`define LCF_CTRL_RST 8'h00
`define LCF_EN_BIT 7
`define LCF_OUT_BIT 5
`define LCF_RISE_BIT 4
`define LCF_FALL_BIT 3
`define LCF_MODE_LSB 0
`define LCF_OINV_BIT 7
`define LCF_CTRL_WMASK 8'h9f
`define LCF_POL_WMASK 8'h8f
`endif

// *** include/lcf_pkg.sv ***
// types shared by the logic cell output stage
package lcf_pkg;
   typedef enum logic [2:0] {
      LCF_AND_OR, LCF_OR_XOR, LCF_AND4, LCF_SR_LATCH,
      LCF_DFF_SR, LCF_DFF2_R, LCF_JK_R, LCF_DLATCH_SR
   } lcf_mode_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] pol;
      logic store;
      logic out_prev;
      logic ck_prev;
      logic flag;
      logic [31:0] rdata;
      logic ack;
      logic [3:0] gate_s1;
      logic [3:0] gate_s2;
   } lcf_state_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } lcf_wb_req_t;
endpackage

// *** verification/lcf_far_end.sv ***
// model of the other cells whose outputs share the mirror register
`timescale 1ns/1ps
module lcf_far_end (
   input wire logic clk_i,
   output logic [3:0] others_o
);
   logic junk_r = 1'b0;
   // own slot toggles every cycle: the cell must put its own output there
   always @(posedge clk_i) begin
      junk_r <= ~junk_r;
   end
   assign others_o = {2'b10, junk_r, 1'b0};
endmodule // lcf_far_end

// *** verification/lcf_cell_tb_top.sv ***
// register-level bench for the logic cell output stage
`timescale 1ns/1ps
`include "lcf_map.svh"
module lcf_cell_tb_top;
   import lcf_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, fsel = 1'b0, e, ack_o, cout, flag, fkeep;
   logic [3:0] gate = 4'h0, sel = 4'h1, others;
   logic [31:0] rd, dat_o;
   lcf_wb_req_t req = '0;
   int err_count = 0, checked = 0, cycles = 0;
   // mode, gates, expected output; storage modes start from their reset gate
   logic [11:0] tbl [23] = '{12'h440, 12'h420, 12'h431, 12'h421, 12'h440, 12'h481,
      12'h640, 12'h620, 12'h631, 12'h6a1, 12'h6b0, 12'h740, 12'h721, 12'h731, 12'h711,
      12'h340, 12'h311, 12'h301, 12'h380, 12'h540, 12'h5b1, 12'h5a1, 12'h530};
   always #5 clk_i = ~clk_i;
   lcf_far_end lcf_far_end_inst (.clk_i(clk_i), .others_o(others));
   lcf_cell #(.NUM_CELLS(4), .CELL_INDEX(1)) lcf_cell_inst (.clk_i(clk_i), .rst_i(rst_i),
      .gate_raw_i(gate), .fosc_selected_i(fsel), .other_out_i(others), .cyc_i(req.cyc),
      .stb_i(req.stb), .we_i(req.we), .adr_i(req.adr), .sel_i(req.sel), .dat_i(req.dat),
      .dat_o(dat_o), .ack_o(ack_o), .cell_output_signal_o(cout),
      .cell_irq_flag_o(flag), .fosc_keep_o(fkeep));
   //////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (err_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one classic cycle; waits for ack without assuming its latency
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      req <= '{1'b1, 1'b1, w, a, sel, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      req <= '{1'b0, 1'b0, 1'b0, a, sel, d};
      if (n >= 50) begin
         err_count++;
         tally_and_finish();
      end
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // gates cross a two-flop synchroniser, so allow a few cycles to land
   task automatic setg(input logic [3:0] g);
      @(posedge clk_i);
      gate <= g;
      repeat (4) @(posedge clk_i);
   endtask
   function automatic logic fexp(input logic [2:0] m, input logic [3:0] g);
      case (m)
         3'h0: return (g[0] & g[1]) | (g[2] & g[3]);
         3'h1: return (g[0] | g[1]) ^ (g[2] | g[3]);
         default: return &g;
      endcase
   endfunction
   //////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 20000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(`LCF_CTRL_OFF, 32'h0);
      wb(1'b1, `LCF_POL_OFF, 32'h5);
      wb(1'b1, `LCF_CTRL_OFF, 32'h40);
      rchk(`LCF_CTRL_OFF, 32'h0);
      wb(1'b1, 4'h2, 32'hff);
      rchk(4'h2, 32'h0);
      for (int m = 0; m < 3; m++) begin
         wb(1'b1, `LCF_CTRL_OFF, 32'h80 | m);
         for (int g = 0; g < 16; g++) begin
            setg(g[3:0]);
            e = fexp(m[2:0], g[3:0] ^ 4'h5);
            chk({31'h0, cout}, {31'h0, e});
            rchk(`LCF_CTRL_OFF, {24'h0, 2'b10, e, 2'b00, m[2:0]});
            rchk(`LCF_MIRROR_OFF, {28'h0, 2'b10, e, 1'b0});
         end
      end
      wb(1'b1, `LCF_CTRL_OFF, 32'h82);
      setg(4'h0);
      wb(1'b1, `LCF_FLAG_OFF, 32'h1);
      wb(1'b1, `LCF_CTRL_OFF, 32'h92);
      // gate change lands after two sync flops, so the edge meets the clear write
      @(posedge clk_i);
      gate <= 4'ha;
      @(posedge clk_i);
      wb(1'b1, `LCF_FLAG_OFF, 32'h1);
      rchk(`LCF_FLAG_OFF, 32'h1);
      wb(1'b1, `LCF_FLAG_OFF, 32'h1);
      setg(4'h0);
      rchk(`LCF_FLAG_OFF, 32'h0);
      wb(1'b1, `LCF_POL_OFF, 32'h85);
      chk({31'h0, cout}, 32'h1);
      rchk(`LCF_FLAG_OFF, 32'h1);
      chk({31'h0, flag}, 32'h1);
      wb(1'b1, `LCF_CTRL_OFF, 32'h8a);
      wb(1'b1, `LCF_FLAG_OFF, 32'h1);
      wb(1'b1, `LCF_POL_OFF, 32'h05);
      rchk(`LCF_FLAG_OFF, 32'h1);
      fsel <= 1'b1;
      wb(1'b1, `LCF_POL_OFF, 32'h85);
      chk({31'h0, fkeep}, 32'h1);
      wb(1'b1, `LCF_CTRL_OFF, 32'h02);
      chk({30'h0, fkeep, cout}, 32'h0);
      sel <= 4'h0;
      wb(1'b1, `LCF_CTRL_OFF, 32'h82);
      sel <= 4'h1;
      rchk(`LCF_CTRL_OFF, 32'h02);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(`LCF_CTRL_OFF, 32'h0);
      rchk(`LCF_POL_OFF, 32'h85);
      wb(1'b1, `LCF_POL_OFF, 32'h0);
      foreach (tbl[i]) begin
         wb(1'b1, `LCF_CTRL_OFF, {24'h0, 5'h10, tbl[i][10:8]});
         setg(tbl[i][7:4]);
         chk({31'h0, cout}, {31'h0, tbl[i][0]});
      end
      tally_and_finish();
   end
endmodule // lcf_cell_tb_top
